// ===== src/flash_host_ctrl.sv
// Flash command host controller: AHB-Lite registers driving the flash pins
`include "flash_host_defs.svh"
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int STROBE = `STROBE_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic             powerdown_n,
    output logic [19:0]      flash_addr,
    output logic [7:0]       flash_dq_o,
    output logic             flash_dq_oe,
    input  wire logic [7:0]  flash_dq_i,
    input  wire logic        ready_busy_pin
);
    // Bus address phase capture
    logic        wr_pend_q, wr_pend_d, rd_pend_q;
    logic [11:0] aoff_q, aoff_d;
    logic        addr_ok;
    assign addr_ok = hsel & hready & htrans[1];

    // Software registers
    logic [3:0]  op_q, op_d;
    logic        pd_q, pd_d;
    logic [19:0] tgt_q, tgt_d;
    logic [7:0]  wd_q, wd_d;
    logic [7:0]  rd_q, rd_d;
    logic [7:0]  fsr_q, fsr_d;
    logic        done_q, done_d;
    logic        go;

    // Sequencer
    seq_state_t  st_q, st_d;
    logic        start;
    cyc_kind_t   kind;
    logic [19:0] cyc_addr;
    logic [7:0]  cyc_data;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;
    logic        kind_was_read_q, kind_was_read_d;

    // Ready/busy pin synchroniser
    logic rb1_q, rb2_q;

    // Bus phase tracking
    always_comb begin
        wr_pend_d = addr_ok & hwrite;
        aoff_d = addr_ok ? haddr[11:0] : aoff_q;
    end

    assign go = wr_pend_q && aoff_q == `REG_CTRL && hwdata[`CTRL_GO_BIT] && st_q == S_IDLE;

    // Command and operand choice per operation
    always_comb begin
        kind = CYC_WRITE;
        cyc_addr = tgt_q;
        cyc_data = `CMD_READ_ARRAY;
        case (st_q)
            S_CYC1: begin
                case (host_op_t'(op_q))
                    OP_READ_ARRAY:  cyc_data = `CMD_READ_ARRAY;
                    OP_READ_ID:     cyc_data = `CMD_IDENT;
                    OP_READ_STATUS: cyc_data = `CMD_READ_STATUS;
                    OP_CLEAR:       cyc_data = `CMD_CLEAR_STAT;
                    OP_ERASE:       cyc_data = `CMD_ERASE_SETUP;
                    OP_PROGRAM:     cyc_data = `CMD_WRITE_SETUP;
                    OP_PROGRAM_ALT: cyc_data = `CMD_WRITE_ALT;
                    OP_SUSPEND:     cyc_data = `CMD_SUSPEND;
                    OP_RESUME:      cyc_data = `CMD_CONFIRM;
                    default:        cyc_data = `CMD_READ_STATUS;
                endcase
            end
            S_CYC2: begin
                case (host_op_t'(op_q))
                    OP_ERASE:       cyc_data = `CMD_CONFIRM;
                    OP_PROGRAM, OP_PROGRAM_ALT: cyc_data = wd_q;
                    default:        kind = CYC_READ;
                endcase
            end
            default: ;
        endcase
    end

    // Sequencer and register next values
    always_comb begin
        st_d = st_q;
        start = 1'b0;
        op_d = op_q;
        pd_d = pd_q;
        tgt_d = tgt_q;
        wd_d = wd_q;
        rd_d = rd_q;
        fsr_d = fsr_q;
        done_d = done_q;
        if (wr_pend_q) begin
            case (aoff_q)
                `REG_CTRL: begin
                    pd_d = hwdata[`CTRL_PD_BIT];
                    if (go) begin
                        op_d = hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
                        done_d = 1'b0;
                    end
                end
                `REG_ADDR:   tgt_d = hwdata[19:0];
                `REG_WDATA:  wd_d = hwdata[7:0];
                `REG_STATUS: if (hwdata[`ST_DONE_BIT]) done_d = 1'b0;
                default: ;
            endcase
        end
        case (st_q)
            S_IDLE: if (go) st_d = S_CYC1;
            S_CYC1: begin
                start = 1'b1;
                st_d = S_WAIT;
            end
            S_WAIT: begin
                if (cyc_done) begin
                    case (host_op_t'(op_q))
                        OP_ERASE, OP_PROGRAM, OP_PROGRAM_ALT, OP_READ_ID, OP_READ_STATUS: begin
                            st_d = S_CYC2;
                            op_d = op_q;
                        end
                        default: begin
                            st_d = S_IDLE;
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            S_CYC2: begin
                start = 1'b1;
                st_d = S_IDLE;
                // Second cycle finishes via the done wait below
                st_d = S_WAIT;
                op_d = 4'hf;
            end
            default: st_d = S_IDLE;
        endcase
        // Completion of the second cycle (op marked finished)
        if (st_q == S_WAIT && cyc_done && op_q == 4'hf) begin
            st_d = S_IDLE;
            done_d = 1'b1;
        end
        if (st_q == S_WAIT && cyc_done && op_q == 4'hf && kind_was_read_q) begin
            rd_d = cyc_rdata;
            fsr_d = cyc_rdata & `SR_RSVD_MASK;
        end
        if (!pd_q) begin
            fsr_d = 8'h80;
        end
    end

    // Remember whether the second cycle reads
    always_comb begin
        kind_was_read_d = kind_was_read_q;
        if (st_q == S_CYC2) kind_was_read_d = (kind == CYC_READ);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            aoff_q <= 12'h000;
            st_q <= S_IDLE;
            op_q <= 4'h0;
            pd_q <= 1'b0;
            tgt_q <= 20'h00000;
            wd_q <= 8'h00;
            rd_q <= 8'h00;
            fsr_q <= 8'h80;
            done_q <= 1'b0;
            kind_was_read_q <= 1'b0;
            rb1_q <= 1'b1;
            rb2_q <= 1'b1;
        end else begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= addr_ok & ~hwrite;
            aoff_q <= aoff_d;
            st_q <= st_d;
            op_q <= op_d;
            pd_q <= pd_d;
            tgt_q <= tgt_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            fsr_q <= fsr_d;
            done_q <= done_d;
            kind_was_read_q <= kind_was_read_d;
            rb1_q <= ready_busy_pin;
            rb2_q <= rb1_q;
        end
    end

    // Read data mux; host status shows ready from the synchronised pin, with done and sequencer busy
    always_comb begin
        hrdata = 32'h00000000;
        if (rd_pend_q) begin
            case (aoff_q)
                `REG_CTRL:     hrdata = {23'h000000, pd_q, op_q, 4'h0};
                `REG_ADDR:     hrdata = {12'h000, tgt_q};
                `REG_WDATA:    hrdata = {24'h000000, wd_q};
                `REG_STATUS:   hrdata = {29'h00000000, done_q, rb2_q, st_q != S_IDLE};
                `REG_RDATA:    hrdata = {24'h000000, rd_q};
                `REG_FLASH_SR: hrdata = {24'h000000, fsr_q};
                default:       hrdata = 32'h00000000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign powerdown_n = pd_q;

    flash_pin_cycle #(
        .STROBE (STROBE)
    ) u_cycle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (start),
        .kind    (kind),
        .addr    (cyc_addr),
        .wdata   (cyc_data),
        .done    (cyc_done),
        .rdata   (cyc_rdata),
        .ce_n    (flash_ce_n),
        .oe_n    (flash_oe_n),
        .we_n    (flash_we_n),
        .a       (flash_addr),
        .dq_o    (flash_dq_o),
        .dq_oe   (flash_dq_oe),
        .dq_i    (flash_dq_i)
    );
endmodule : flash_host_ctrl

// ===== src/flash_host_defs.svh
// Offsets, command codes, status fields and timing counts of the flash host controller
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// Host register word offsets (byte addresses)
`define REG_CTRL        12'h000
`define REG_ADDR        12'h004
`define REG_WDATA       12'h008
`define REG_STATUS      12'h00c
`define REG_RDATA       12'h010
`define REG_FLASH_SR    12'h014

// Control register fields
`define CTRL_GO_BIT     0
`define CTRL_OP_LSB     4
`define CTRL_OP_MSB     7
`define CTRL_PD_BIT     8

// Host status fields
`define ST_BUSY_BIT     0
`define ST_RYBY_BIT     1
`define ST_DONE_BIT     2

// Device command codes
`define CMD_READ_ARRAY  8'hff
`define CMD_IDENT       8'h90
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STAT  8'h50
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM     8'hd0
`define CMD_SUSPEND     8'hb0
`define CMD_WRITE_SETUP 8'h40
`define CMD_WRITE_ALT   8'h10

// Identifier addresses
`define ID_MAKER_ADDR   20'h00000
`define ID_PART_ADDR    20'h00001

// Device status bits
`define SR_READY_BIT    7
`define SR_SUSP_BIT     6
`define SR_ERASE_BIT    5
`define SR_PROG_BIT     4
`define SR_SUPPLY_BIT   3
`define SR_RSVD_MASK    8'hf8

// Pin timing
`define T_STROBE_NS     70
`define CLK_NS          10
`define STROBE_CYC      ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== src/flash_host_pkg.sv
// Types of the flash host controller
package flash_host_pkg;
    // Host operation codes written to the control register
    typedef enum logic [3:0] {
        OP_READ_ARRAY  = 4'h0,
        OP_READ_ID     = 4'h1,
        OP_READ_STATUS = 4'h2,
        OP_CLEAR       = 4'h3,
        OP_ERASE       = 4'h4,
        OP_PROGRAM     = 4'h5,
        OP_SUSPEND     = 4'h6,
        OP_RESUME      = 4'h7,
        OP_PROGRAM_ALT = 4'h8
    } host_op_t;

    // Pin cycle kinds
    typedef enum logic [1:0] {
        CYC_WRITE = 2'h1,
        CYC_READ  = 2'h2
    } cyc_kind_t;

    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_CYC1  = 4'b0010,
        S_CYC2  = 4'b0100,
        S_WAIT  = 4'b1000
    } seq_state_t;
endpackage : flash_host_pkg

// ===== src/flash_pin_cycle.sv
// One write or read cycle on the flash parallel pins
`include "flash_host_defs.svh"
module flash_pin_cycle
    import flash_host_pkg::*;
#(
    parameter int STROBE = `STROBE_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        start,
    input  wire cyc_kind_t   kind,
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  wdata,
    output logic             done,
    output logic [7:0]       rdata,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic [19:0]      a,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_i
);
    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_LOW  = 3'b010,
        P_HIGH = 3'b100
    } pin_state_t;

    pin_state_t  st_q, st_d;
    logic [7:0]  cnt_q, cnt_d;
    logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, oe_q, oe_d;
    logic [19:0] a_q, a_d;
    logic [7:0]  dq_o_q, dq_o_d, rd_q, rd_d;
    logic [7:0]  s1_q, s2_q;
    logic        done_q, done_d;

    // Next values of the pin sequence
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        oe_d = oe_q;
        a_d = a_q;
        dq_o_d = dq_o_q;
        rd_d = rd_q;
        done_d = 1'b0;
        case (st_q)
            P_IDLE: begin
                if (start) begin
                    st_d = P_LOW;
                    cnt_d = 8'(STROBE);
                    a_d = addr;
                    ce_n_d = 1'b0;
                    if (kind == CYC_WRITE) begin
                        we_n_d = 1'b0;
                        oe_d = 1'b1;
                        dq_o_d = wdata;
                    end else begin
                        oe_n_d = 1'b0;
                    end
                end
            end
            P_LOW: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    // Rising write strobe latches address and data; both pins go high
                    st_d = P_HIGH;
                    cnt_d = 8'(STROBE);
                    if (!oe_n_q) rd_d = s2_q;
                    we_n_d = 1'b1;
                    oe_n_d = 1'b1;
                end
            end
            P_HIGH: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h00) begin
                    st_d = P_IDLE;
                    ce_n_d = 1'b1;
                    oe_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            default: st_d = P_IDLE;
        endcase
    end

    // Pin and state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= P_IDLE;
            cnt_q <= 8'h00;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_q <= 1'b0;
            a_q <= 20'h00000;
            dq_o_q <= 8'h00;
            rd_q <= 8'h00;
            done_q <= 1'b0;
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            oe_q <= oe_d;
            a_q <= a_d;
            dq_o_q <= dq_o_d;
            rd_q <= rd_d;
            done_q <= done_d;
            s1_q <= dq_i; // Data pin synchroniser
            s2_q <= s1_q;
        end
    end

    assign done = done_q;
    assign rdata = rd_q;
    assign ce_n = ce_n_q;
    assign oe_n = oe_n_q;
    assign we_n = we_n_q;
    assign a = a_q;
    assign dq_o = dq_o_q;
    assign dq_oe = oe_q;
endmodule : flash_pin_cycle

// ===== testbench/flash_device_model.sv
// Behavioural model of the flash command interface and status register
module flash_device_model #(
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
    parameter logic [7:0] PART  = 8'h5e, // Arbitrary value
    parameter int         BUSY  = 300
) (
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic        powerdown_n,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0]  flash_dq,
    input wire logic        supply_ok,
    output logic [7:0]      dev_dq,
    output logic            ready_busy_pin,
    output logic            in_array,
    output logic [7:0]      last_cmd,
    output logic [7:0]      prev_cmd,
    output logic [19:0]     last_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef enum logic [1:0] {M_ARRAY, M_ID, M_STAT} mode_t;
    mode_t      mode;
    logic [7:0] setup, sr_latch, last_out;
    logic       susp, e_err, p_err, v_low;
    int         left;
    wire        busy = left != 0 && !susp;
    wire        drv  = !flash_ce_n && !flash_oe_n && powerdown_n;
    wire [7:0]  sr   = {!busy, susp, e_err, p_err, v_low, 3'h0};
    wire [7:0]  rd   = mode == M_STAT ? sr_latch : mode == M_ID ? (flash_addr[0] ? PART : MAKER) : flash_addr[7:0];

    assign ready_busy_pin = !busy;
    assign in_array = mode == M_ARRAY;
    assign dev_dq = drv ? rd : ~last_out;

    // Back to read array with clean flags
    task automatic clr();
        mode = M_ARRAY;
        setup = 8'h00;
        susp = 1'b0;
        left = 0;
        {e_err, p_err, v_low} = 3'h0;
    endtask : clr
    // Supply sampled only once a full sequence is in
    task automatic start();
        mode = M_STAT;
        if (!supply_ok) v_low = 1'b1;
        else left = BUSY;
    endtask : start

    initial begin
        last_out = 8'h00;
        last_cmd = 8'h00;
        clr();
    end
    always @(negedge powerdown_n) clr();
    always #10 if (left > 0 && !susp) left--;
    // Status snapshot on the later falling strobe
    always @(negedge flash_oe_n or negedge flash_ce_n) if (!flash_ce_n && !flash_oe_n && powerdown_n) sr_latch = sr;
    always @(drv or rd) if (drv) last_out = rd;
    // Command latch on the rising write strobe
    always @(posedge flash_we_n) if (!flash_ce_n && powerdown_n) begin
        prev_cmd = last_cmd;
        last_cmd = flash_dq;
        last_addr = flash_addr;
        if (setup == 8'h20) begin
            setup = 8'h00;
            mode = M_STAT;
            if (flash_dq != 8'hd0) {e_err, p_err} = 2'h3;
            else start();
        end else if (setup == 8'h40) begin
            setup = 8'h00;
            start();
        end else case (flash_dq)
            8'hff: if (!busy) mode = M_ARRAY;
            8'h90: mode = M_ID;
            8'h70: mode = M_STAT;
            8'h50: {e_err, p_err, v_low} = 3'h0;
            8'h20: setup = 8'h20;
            8'h40, 8'h10: setup = 8'h40;
            8'hb0: if (busy) susp = 1'b1;
            8'hd0: if (susp) susp = 1'b0;
            default: ;
        endcase
    end
endmodule : flash_device_model

// ===== testbench/flash_host_ctrl_properties.sv
// Checker of the flash host controller pin and bus behaviour
module flash_host_ctrl_properties #(
    parameter int STROBE = 2
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic        powerdown_n,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0]  flash_dq_o,
    input wire logic        flash_dq_oe
);
    logic [7:0] we_low_q;
    logic [7:0] we_low_d;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Count of sampled low cycles of the write strobe
    always_comb begin
        we_low_d = flash_we_n ? 8'h00 : we_low_q + 8'h01;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            we_low_q <= 8'h00;
        end else begin
            we_low_q <= we_low_d;
        end
    end

    property p_we_select;
        !flash_we_n |-> !flash_ce_n && flash_oe_n;
    endproperty
    a_we_select: assert property (p_we_select)
        else $error("write strobe without select");
    property p_we_width;
        $rose(flash_we_n) |-> we_low_q == 8'(STROBE + 1);
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe width wrong");
    property p_wr_hold;
        !flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_o) && $stable(flash_addr) && flash_dq_oe;
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write operands moved");
    property p_rd_release;
        !flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("read cycle with data driven");
    property p_oe_gap;
        $rose(flash_oe_n) |-> flash_oe_n [*3];
    endproperty
    a_oe_gap: assert property (p_oe_gap)
        else $error("output enable gap too short");
    property p_cycle_end;
        $fell(flash_ce_n) |-> ##[1:60] $rose(flash_ce_n);
    endproperty
    a_cycle_end: assert property (p_cycle_end)
        else $error("pin cycle does not end");
    property p_pd_quiet;
        !powerdown_n |-> flash_we_n && flash_oe_n && !flash_dq_oe;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet)
        else $error("pins active in power-down");
    property p_bus_ok;
        hreadyout && !hresp;
    endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("bus wait or error");
    property p_unmapped;
        hsel && hready && htrans[1] && !hwrite && haddr[11:0] == 12'h020 |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule : flash_host_ctrl_properties

// ===== testbench/test_flash_host_ctrl.sv
// Testbench of the flash command host controller
`include "flash_host_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_flash_host_ctrl
    import flash_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STROBE = 2;
    logic        hclk, hresetn, hsel, hwrite, supply_ok;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, flash_ce_n, flash_oe_n, flash_we_n, powerdown_n, flash_dq_oe;
    logic [19:0] flash_addr, last_addr;
    logic [7:0]  flash_dq_o, dev_dq, last_cmd, prev_cmd;
    logic        ready_busy_pin, in_array;
    int          n_errors, checks_done;
    wire logic   hready = hreadyout;
    wire logic [7:0] flash_dq_i = flash_dq_oe ? flash_dq_o : dev_dq;

    flash_host_ctrl #(.STROBE(STROBE)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .flash_ce_n, .flash_oe_n, .flash_we_n,
        .powerdown_n, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .ready_busy_pin);
    flash_device_model dev (.flash_ce_n, .flash_oe_n, .flash_we_n, .powerdown_n, .flash_addr,
        .flash_dq(flash_dq_i), .supply_ok, .dev_dq, .ready_busy_pin, .in_array, .last_cmd, .prev_cmd, .last_addr);

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // One single AHB transfer, each phase bounded
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hready !== 1'b1 && n < 20);
            if (hready !== 1'b1) begin
                n_errors++;
                close_out();
            end
            if (ph == 0) begin
                hsel <= 1'b0;
                htrans <= 2'h0;
                hwdata <= wd;
            end
        end
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        `CHK(nm, e, x)
    endtask : rd_chk
    // Start an operation and wait for its done flag
    task automatic op(input host_op_t o);
        logic [31:0] s;
        wr(`REG_CTRL, {23'h0, 1'b1, o, 4'h1});
        s = 32'h0;
        for (int i = 0; i < 100 && s[`ST_DONE_BIT] !== 1'b1; i++) ahb(1'b0, `REG_STATUS, 32'h0, s);
        `CHK("done", 1'b1, s[`ST_DONE_BIT])
        wr(`REG_STATUS, 32'h4);
    endtask : op
    task automatic sr_chk(input string nm, input logic [31:0] e);
        op(OP_READ_STATUS);
        rd_chk(nm, `REG_FLASH_SR, e);
    endtask : sr_chk
    // Poll status until the engine reports ready
    task automatic wait_ready();
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 100 && s[7] !== 1'b1; i++) begin
            op(OP_READ_STATUS);
            ahb(1'b0, `REG_FLASH_SR, 32'h0, s);
        end
        `CHK("ready", 1'b1, s[7])
    endtask : wait_ready

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Hang limit
    initial begin
        repeat (90000) @(posedge hclk);
        n_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        supply_ok = 1'b1;
        n_errors = 0;
        checks_done = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("status", `REG_STATUS, 32'h2);
        rd_chk("flash_sr", `REG_FLASH_SR, 32'h80);
        wr(12'h020, 32'hffff_ffff);
        rd_chk("unmapped", 12'h020, 32'h0);
        $display("test reset done");
        wr(`REG_CTRL, 32'h100);
        `CHK("array", 1'b1, in_array)
        for (int i = 0; i < 2; i++) begin
            wr(`REG_ADDR, i);
            op(OP_READ_ID);
            rd_chk("ident", `REG_RDATA, {24'h0, i ? dev.PART : dev.MAKER});
        end
        `CHK("id_cmd", 8'h90, last_cmd)
        $display("test ident done");
        wr(`REG_ADDR, 32'h3_0010);
        op(OP_ERASE);
        `CHK("erase", {8'h20, 8'hd0, 20'h30010}, {prev_cmd, last_cmd, last_addr})
        sr_chk("busy", 32'h00);
        op(OP_READ_ARRAY);
        `CHK("ignored", 1'b0, in_array)
        op(OP_SUSPEND);
        sr_chk("suspend", 32'hc0);
        op(OP_RESUME);
        sr_chk("resume", 32'h00);
        wait_ready();
        sr_chk("erase_ok", 32'h80);
        op(OP_READ_ARRAY);
        `CHK("array", 1'b1, in_array)
        $display("test erase done");
        supply_ok <= 1'b0;
        wr(`REG_ADDR, 32'h0_1234);
        wr(`REG_WDATA, 32'ha5);
        op(OP_PROGRAM);
        `CHK("prog", {8'h40, 8'ha5, 20'h01234}, {prev_cmd, last_cmd, last_addr})
        sr_chk("supply", 32'h88);
        supply_ok <= 1'b1;
        sr_chk("sticky", 32'h88);
        op(OP_CLEAR);
        sr_chk("clear", 32'h80);
        op(OP_PROGRAM_ALT);
        `CHK("alt", 8'h10, prev_cmd)
        wait_ready();
        sr_chk("prog_ok", 32'h80);
        op(host_op_t'(4'h9));
        `CHK("rsvd_op", `CMD_READ_STATUS, last_cmd)
        supply_ok <= 1'b0;
        op(OP_PROGRAM);
        sr_chk("vlow", 32'h88);
        $display("test program done");
        wr(`REG_CTRL, 32'h0);
        rd_chk("pd_sr", `REG_FLASH_SR, 32'h80);
        `CHK("pd_array", 1'b1, in_array)
        wr(`REG_CTRL, 32'h100);
        sr_chk("wake", 32'h80);
        $display("test powerdown done");
        close_out();
    end
endmodule : test_flash_host_ctrl

bind flash_host_ctrl flash_host_ctrl_properties #(.STROBE(STROBE)) u_props (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .powerdown_n, .flash_addr, .flash_dq_o, .flash_dq_oe);
